// ### design/sspsl_fifo.sv
// Shared constants and the receive word FIFO of the serial port signal layer
package sspsl_pkg;
   // Pin indices into the six-wide pin vectors
   localparam int NPINS = 6;
   localparam int PIN_ZERO = 0;
   localparam int PIN_ONE = 1;
   localparam int PIN_TWO = 2;
   localparam int PIN_BCLK = 3;
   localparam int PIN_RXD = 4;
   localparam int PIN_TXD = 5;
   // Framing
   localparam int WORD_W = 16;
   localparam int BIT_W = 4;
   localparam logic [BIT_W-1:0] BIT_LAST = 4'hF;
   localparam logic [BIT_W-1:0] BIT_FIRST = 4'h0;
   localparam logic [BIT_W-1:0] BIT_STEP = 4'h1;
   // Internal bit clock: half period as printed time, cycles derived (least time, rounded up)
   localparam int REF_PERIOD_NS = 25;
   localparam int CLK_HALF_NS = 100;
   localparam int CLK_HALF_CYC = (CLK_HALF_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
   localparam int DIV_W = 3;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CLK_HALF_CYC - 1);
   localparam logic [DIV_W-1:0] DIV_STEP = 3'h1;
   // FIFO
   localparam int RX_FIFO_DEPTH = 8;
   // Reset values
   localparam logic [NPINS-1:0] PIN_OE_N_RST = 6'h3F;
   localparam logic [NPINS-1:0] PIN_ALL_LOW = 6'h00;
   localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
   typedef enum logic [0:0] {
      SSPSL_TX_IDLE = 1'b0,
      SSPSL_TX_SHIFT = 1'b1
   } sspsl_tx_e;
endpackage

module sspsl_fifo #(
   parameter int WIDTH = sspsl_pkg::WORD_W,
   parameter int DEPTH = sspsl_pkg::RX_FIFO_DEPTH
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int PTR_W = $clog2(DEPTH);
   localparam int CNT_W = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PTR_W-1:0] wr_ptr_q;
   logic [PTR_W-1:0] rd_ptr_q;
   logic [CNT_W-1:0] count_q;
   logic push;
   logic pop;

   assign in_ready_o = (count_q != CNT_W'(DEPTH));
   assign push = in_valid_i && in_ready_o;
   // Output stage is a register so the consumer sees flop-driven data
   assign pop = (count_q != '0) && (!out_valid_o || out_ready_i);

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_q + PTR_W'(1);
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_q + PTR_W'(1);
         end
         count_q <= count_q + CNT_W'(push) - CNT_W'(pop);
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         out_valid_o <= 1'b0;
         out_data_o <= '0;
      end else if (pop) begin
         out_valid_o <= 1'b1;
         out_data_o <= mem_q[rd_ptr_q];
      end else if (out_ready_i) begin
         out_valid_o <= 1'b0;
      end
   end
endmodule // sspsl_fifo

// ### design/sspsl_top.sv
// Pin layer of one synchronous serial port: pin muxing, bit clock, framing and shifters
module sspsl_top (
   input wire logic REF_CLK_I,
   input wire logic RSTN_I,
   input wire logic SERIAL_CTRL_PIN_ZERO_I,
   output logic SERIAL_CTRL_PIN_ZERO_O,
   output logic SERIAL_CTRL_PIN_ZERO_OE_N_O,
   input wire logic SERIAL_CTRL_PIN_ONE_I,
   output logic SERIAL_CTRL_PIN_ONE_O,
   output logic SERIAL_CTRL_PIN_ONE_OE_N_O,
   input wire logic SERIAL_CTRL_PIN_TWO_I,
   output logic SERIAL_CTRL_PIN_TWO_O,
   output logic SERIAL_CTRL_PIN_TWO_OE_N_O,
   input wire logic PORT_BIT_CLOCK_PIN_I,
   output logic PORT_BIT_CLOCK_PIN_O,
   output logic PORT_BIT_CLOCK_PIN_OE_N_O,
   input wire logic PORT_RECEIVE_DATA_PIN_I,
   output logic PORT_RECEIVE_DATA_PIN_O,
   output logic PORT_RECEIVE_DATA_PIN_OE_N_O,
   input wire logic PORT_TRANSMIT_DATA_PIN_I,
   output logic PORT_TRANSMIT_DATA_PIN_O,
   output logic PORT_TRANSMIT_DATA_PIN_OE_N_O,
   input wire logic [5:0] GP_CTRL_I,
   input wire logic [5:0] GP_DIR_I,
   input wire logic [5:0] GP_OUT_I,
   output logic [5:0] GP_LEVEL_O,
   input wire logic SYNC_MODE_I,
   input wire logic CLK_OUT_I,
   input wire logic FS_OUT_I,
   input wire logic [1:0] FLAG_I,
   input wire logic [1:0] XTX_EN_I,
   input wire logic STOP_I,
   output logic [5:0] KEEP_EN_O,
   input wire logic [15:0] TX_WORD_I,
   output logic TX_TAKEN_O,
   output logic [15:0] RX_DATA_O,
   output logic RX_VALID_O,
   input wire logic RX_READY_I,
   output logic RX_OVERRUN_O,
   input wire logic RX_OVR_CLR_I
);
   localparam int NP = sspsl_pkg::NPINS;
   localparam int WW = sspsl_pkg::WORD_W;
   localparam int BW = sspsl_pkg::BIT_W;

   // Serial function wins over the general-purpose port bit only when selected
   function automatic logic [1:0] pin_mux(input logic sel, input logic fn_out,
                                          input logic fn_oe_n, input logic gp_out,
                                          input logic gp_dir);
      pin_mux = sel ? {fn_out, fn_oe_n} : {gp_out, ~gp_dir};
   endfunction

   function automatic logic [BW-1:0] bit_next(input logic [BW-1:0] cnt);
      bit_next = (cnt == sspsl_pkg::BIT_LAST) ? sspsl_pkg::BIT_FIRST : cnt + sspsl_pkg::BIT_STEP;
   endfunction

   // ---------------- Pad input synchronisers (system clock) ----------------
   logic [NP-1:0] pad_raw;
   logic [NP-1:0] pad_s1_q;
   logic [NP-1:0] pad_s2_q;

   assign pad_raw = {PORT_TRANSMIT_DATA_PIN_I, PORT_RECEIVE_DATA_PIN_I, PORT_BIT_CLOCK_PIN_I,
                     SERIAL_CTRL_PIN_TWO_I, SERIAL_CTRL_PIN_ONE_I, SERIAL_CTRL_PIN_ZERO_I};

   always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         pad_s1_q <= sspsl_pkg::PIN_ALL_LOW;
         pad_s2_q <= sspsl_pkg::PIN_ALL_LOW;
      end else begin
         pad_s1_q <= pad_raw;
         pad_s2_q <= pad_s1_q;
      end
   end

   // ---------------- Internal bit clock divider ----------------
   logic [sspsl_pkg::DIV_W-1:0] div_cnt_q;
   logic div_clk_q;

   // Half period never below three system cycles, so the partner sees a legal clock
   always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         div_cnt_q <= '0;
         div_clk_q <= 1'b0;
      end else if (!CLK_OUT_I) begin
         div_cnt_q <= '0;
         div_clk_q <= 1'b0;
      end else if (div_cnt_q == sspsl_pkg::DIV_LAST) begin
         div_cnt_q <= '0;
         div_clk_q <= ~div_clk_q;
      end else begin
         div_cnt_q <= div_cnt_q + sspsl_pkg::DIV_STEP;
      end
   end

   // ---------------- Bit clock edge detection ----------------
   logic sck_now;
   logic sck_prev_q;
   logic sck_rise;
   logic sck_fall;

   // Edge detection reads the external clock after two flops; edges need 3 cycles per half
   assign sck_now = CLK_OUT_I ? div_clk_q : pad_s2_q[sspsl_pkg::PIN_BCLK];
   assign sck_rise = sck_now && !sck_prev_q;
   assign sck_fall = !sck_now && sck_prev_q;

   always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         sck_prev_q <= 1'b0;
      end else begin
         sck_prev_q <= sck_now;
      end
   end

   // ---------------- Transmit frame sync ----------------
   logic [BW-1:0] fs_cnt_q;
   logic fs_gen_q;
   logic fs_seen_q;
   logic tx_load;

   // Frame sync is high for the bit period just before the first data bit
   always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         fs_cnt_q <= sspsl_pkg::BIT_FIRST;
         fs_gen_q <= 1'b0;
      end else if (!FS_OUT_I) begin
         fs_cnt_q <= sspsl_pkg::BIT_FIRST;
         fs_gen_q <= 1'b0;
      end else if (sck_fall) begin
         fs_cnt_q <= bit_next(fs_cnt_q);
         fs_gen_q <= (bit_next(fs_cnt_q) == sspsl_pkg::BIT_LAST);
      end
   end

   // Partner frame sync sampled on bit clock rise, acted on at the next fall
   always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         fs_seen_q <= 1'b0;
      end else if (FS_OUT_I) begin
         fs_seen_q <= 1'b0;
      end else if (sck_rise) begin
         fs_seen_q <= pad_s2_q[sspsl_pkg::PIN_TWO];
      end else if (sck_fall) begin
         fs_seen_q <= 1'b0;
      end
   end

   assign tx_load = sck_fall && GP_CTRL_I[sspsl_pkg::PIN_TXD] &&
                    (FS_OUT_I ? (fs_cnt_q == sspsl_pkg::BIT_LAST) : fs_seen_q);

   // ---------------- Transmit shifter ----------------
   sspsl_pkg::sspsl_tx_e tx_state_q;
   logic [WW-1:0] tx_sh_q;
   logic [BW-1:0] tx_left_q;
   logic tx_taken_q;
   logic tx_bit;

   assign tx_bit = tx_sh_q[WW-1];

   always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         tx_state_q <= sspsl_pkg::SSPSL_TX_IDLE;
         tx_sh_q <= sspsl_pkg::WORD_RST;
         tx_left_q <= sspsl_pkg::BIT_FIRST;
      end else if (tx_load) begin
         tx_state_q <= sspsl_pkg::SSPSL_TX_SHIFT;
         tx_sh_q <= TX_WORD_I;
         tx_left_q <= sspsl_pkg::BIT_LAST;
      end else if (sck_fall) begin
         case (tx_state_q)
            sspsl_pkg::SSPSL_TX_SHIFT: begin
               if (tx_left_q == sspsl_pkg::BIT_FIRST) begin
                  tx_state_q <= sspsl_pkg::SSPSL_TX_IDLE;
               end else begin
                  tx_sh_q <= {tx_sh_q[WW-2:0], 1'b0};
                  tx_left_q <= tx_left_q - sspsl_pkg::BIT_STEP;
               end
            end
            default: begin
               tx_state_q <= sspsl_pkg::SSPSL_TX_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         tx_taken_q <= 1'b0;
      end else begin
         tx_taken_q <= tx_load;
      end
   end

   // ---------------- Serial function of each pin ----------------
   logic [NP-1:0] fn_out;
   logic [NP-1:0] fn_oe_n;
   logic tx_active;

   assign tx_active = (tx_state_q == sspsl_pkg::SSPSL_TX_SHIFT);

   always_comb begin
      fn_out = sspsl_pkg::PIN_ALL_LOW;
      fn_oe_n = sspsl_pkg::PIN_OE_N_RST;
      // Async receive clock and receive frame sync are taken as inputs here
      if (SYNC_MODE_I) begin
         fn_out[sspsl_pkg::PIN_ZERO] = XTX_EN_I[0] ? tx_bit : FLAG_I[0];
         fn_oe_n[sspsl_pkg::PIN_ZERO] = XTX_EN_I[0] ? !tx_active : 1'b0;
         fn_out[sspsl_pkg::PIN_ONE] = XTX_EN_I[1] ? tx_bit : FLAG_I[1];
         fn_oe_n[sspsl_pkg::PIN_ONE] = XTX_EN_I[1] ? !tx_active : 1'b0;
      end
      fn_out[sspsl_pkg::PIN_TWO] = fs_gen_q;
      fn_oe_n[sspsl_pkg::PIN_TWO] = !FS_OUT_I;
      fn_out[sspsl_pkg::PIN_BCLK] = div_clk_q;
      fn_oe_n[sspsl_pkg::PIN_BCLK] = !CLK_OUT_I;
      fn_oe_n[sspsl_pkg::PIN_RXD] = 1'b1;
      fn_out[sspsl_pkg::PIN_TXD] = tx_bit;
      fn_oe_n[sspsl_pkg::PIN_TXD] = !tx_active;
   end

   // ---------------- Pin output registers, stop handling ----------------
   logic [NP-1:0] pin_out_q;
   logic [NP-1:0] pin_oe_n_q;
   logic [NP-1:0] keep_q;
   logic [NP-1:0] level_q;
   logic stop_q;
   logic [1:0] mux_res [NP];

   always_comb begin
      for (int i = 0; i < NP; i++) begin
         mux_res[i] = pin_mux(GP_CTRL_I[i], fn_out[i], fn_oe_n[i], GP_OUT_I[i], GP_DIR_I[i]);
      end
   end

   // No wait input exists: the wait state cannot disturb any pin
   always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         pin_out_q <= sspsl_pkg::PIN_ALL_LOW;
         pin_oe_n_q <= sspsl_pkg::PIN_OE_N_RST;
         keep_q <= sspsl_pkg::PIN_ALL_LOW;
         stop_q <= 1'b0;
      end else begin
         stop_q <= STOP_I;
         if (STOP_I && !stop_q) begin
            keep_q <= ~pin_oe_n_q;
            pin_oe_n_q <= sspsl_pkg::PIN_OE_N_RST;
         end else if (!STOP_I) begin
            keep_q <= sspsl_pkg::PIN_ALL_LOW;
            for (int i = 0; i < NP; i++) begin
               pin_out_q[i] <= mux_res[i][1];
               pin_oe_n_q[i] <= mux_res[i][0];
            end
         end
      end
   end

   // Pin levels as seen by software; frozen in stop so inputs are ignored
   always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         level_q <= sspsl_pkg::PIN_ALL_LOW;
      end else if (!STOP_I) begin
         level_q <= pad_s2_q;
      end
   end

   // ---------------- Receive shifter on the bit clock pin ----------------
   logic rx_cfg_q;
   logic lk_en_s1_q;
   logic lk_en_s2_q;
   logic lk_armed_q;
   logic [BW-1:0] lk_cnt_q;
   logic [WW-1:0] lk_sh_q;
   logic [WW-1:0] lk_word_q;
   logic lk_tog_q;

   always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         rx_cfg_q <= 1'b0;
      end else begin
         rx_cfg_q <= GP_CTRL_I[sspsl_pkg::PIN_RXD] && SYNC_MODE_I && !STOP_I;
      end
   end

   always_ff @(posedge PORT_BIT_CLOCK_PIN_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         lk_en_s1_q <= 1'b0;
         lk_en_s2_q <= 1'b0;
      end else begin
         lk_en_s1_q <= rx_cfg_q;
         lk_en_s2_q <= lk_en_s1_q;
      end
   end

   // Frame sync on pin two marks the next bit as the first of a word
   always_ff @(posedge PORT_BIT_CLOCK_PIN_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         lk_armed_q <= 1'b0;
         lk_cnt_q <= sspsl_pkg::BIT_FIRST;
         lk_sh_q <= sspsl_pkg::WORD_RST;
         lk_word_q <= sspsl_pkg::WORD_RST;
         lk_tog_q <= 1'b0;
      end else if (!lk_en_s2_q) begin
         lk_armed_q <= 1'b0;
         lk_cnt_q <= sspsl_pkg::BIT_FIRST;
      end else begin
         if (lk_armed_q) begin
            lk_sh_q <= {lk_sh_q[WW-2:0], PORT_RECEIVE_DATA_PIN_I};
            lk_cnt_q <= lk_cnt_q + sspsl_pkg::BIT_STEP;
            if (lk_cnt_q == sspsl_pkg::BIT_LAST) begin
               lk_word_q <= {lk_sh_q[WW-2:0], PORT_RECEIVE_DATA_PIN_I};
               lk_tog_q <= ~lk_tog_q;
               lk_armed_q <= 1'b0;
            end
         end
         if (SERIAL_CTRL_PIN_TWO_I) begin
            lk_armed_q <= 1'b1;
            lk_cnt_q <= sspsl_pkg::BIT_FIRST;
         end
      end
   end

   // ---------------- Word crossing into the system clock ----------------
   logic tog_s1_q;
   logic tog_s2_q;
   logic tog_s3_q;
   logic rx_new;
   logic fifo_in_ready;
   logic overrun_q;

   always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         tog_s1_q <= 1'b0;
         tog_s2_q <= 1'b0;
         tog_s3_q <= 1'b0;
      end else begin
         tog_s1_q <= lk_tog_q;
         tog_s2_q <= tog_s1_q;
         tog_s3_q <= tog_s2_q;
      end
   end

   // Word register stays still for a whole word time after the toggle moves
   assign rx_new = tog_s2_q ^ tog_s3_q;

   // The partner clock cannot be stalled, so a full FIFO drops the word
   always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         overrun_q <= 1'b0;
      end else if (rx_new && !fifo_in_ready) begin
         overrun_q <= 1'b1;
      end else if (RX_OVR_CLR_I) begin
         overrun_q <= 1'b0;
      end
   end

   sspsl_fifo #(
      .WIDTH(sspsl_pkg::WORD_W),
      .DEPTH(sspsl_pkg::RX_FIFO_DEPTH)
   ) u_rx_fifo (
      .clk_i(REF_CLK_I),
      .rst_n_i(RSTN_I),
      .in_valid_i(rx_new),
      .in_ready_o(fifo_in_ready),
      .in_data_i(lk_word_q),
      .out_valid_o(RX_VALID_O),
      .out_ready_i(RX_READY_I),
      .out_data_o(RX_DATA_O)
   );

   // ---------------- Outputs ----------------
   assign SERIAL_CTRL_PIN_ZERO_O = pin_out_q[sspsl_pkg::PIN_ZERO];
   assign SERIAL_CTRL_PIN_ZERO_OE_N_O = pin_oe_n_q[sspsl_pkg::PIN_ZERO];
   assign SERIAL_CTRL_PIN_ONE_O = pin_out_q[sspsl_pkg::PIN_ONE];
   assign SERIAL_CTRL_PIN_ONE_OE_N_O = pin_oe_n_q[sspsl_pkg::PIN_ONE];
   assign SERIAL_CTRL_PIN_TWO_O = pin_out_q[sspsl_pkg::PIN_TWO];
   assign SERIAL_CTRL_PIN_TWO_OE_N_O = pin_oe_n_q[sspsl_pkg::PIN_TWO];
   assign PORT_BIT_CLOCK_PIN_O = pin_out_q[sspsl_pkg::PIN_BCLK];
   assign PORT_BIT_CLOCK_PIN_OE_N_O = pin_oe_n_q[sspsl_pkg::PIN_BCLK];
   assign PORT_RECEIVE_DATA_PIN_O = pin_out_q[sspsl_pkg::PIN_RXD];
   assign PORT_RECEIVE_DATA_PIN_OE_N_O = pin_oe_n_q[sspsl_pkg::PIN_RXD];
   assign PORT_TRANSMIT_DATA_PIN_O = pin_out_q[sspsl_pkg::PIN_TXD];
   assign PORT_TRANSMIT_DATA_PIN_OE_N_O = pin_oe_n_q[sspsl_pkg::PIN_TXD];
   assign GP_LEVEL_O = level_q;
   assign KEEP_EN_O = keep_q;
   assign TX_TAKEN_O = tx_taken_q;
   assign RX_OVERRUN_O = overrun_q;
endmodule // sspsl_top

// ### test/sspsl_sva.sv
// Port-level assertions for the serial port pin layer
module sspsl_sva (
   input wire logic REF_CLK_I,
   input wire logic RSTN_I,
   input wire logic SERIAL_CTRL_PIN_ZERO_O,
   input wire logic SERIAL_CTRL_PIN_ZERO_OE_N_O,
   input wire logic SERIAL_CTRL_PIN_ONE_O,
   input wire logic SERIAL_CTRL_PIN_ONE_OE_N_O,
   input wire logic SERIAL_CTRL_PIN_TWO_OE_N_O,
   input wire logic PORT_BIT_CLOCK_PIN_OE_N_O,
   input wire logic PORT_RECEIVE_DATA_PIN_OE_N_O,
   input wire logic PORT_TRANSMIT_DATA_PIN_O,
   input wire logic PORT_TRANSMIT_DATA_PIN_OE_N_O,
   input wire logic [5:0] GP_CTRL_I,
   input wire logic [5:0] GP_DIR_I,
   input wire logic [5:0] GP_OUT_I,
   input wire logic [5:0] GP_LEVEL_O,
   input wire logic SYNC_MODE_I,
   input wire logic CLK_OUT_I,
   input wire logic FS_OUT_I,
   input wire logic [1:0] FLAG_I,
   input wire logic [1:0] XTX_EN_I,
   input wire logic STOP_I,
   input wire logic [5:0] KEEP_EN_O,
   input wire logic TX_TAKEN_O,
   input wire logic RX_VALID_O,
   input wire logic RX_READY_I,
   input wire logic RX_OVERRUN_O
);
   logic [5:0] oe_n;
   logic [1:0] ctl_o;
   assign oe_n = {PORT_TRANSMIT_DATA_PIN_OE_N_O, PORT_RECEIVE_DATA_PIN_OE_N_O,
      PORT_BIT_CLOCK_PIN_OE_N_O, SERIAL_CTRL_PIN_TWO_OE_N_O, SERIAL_CTRL_PIN_ONE_OE_N_O,
      SERIAL_CTRL_PIN_ZERO_OE_N_O};
   assign ctl_o = {SERIAL_CTRL_PIN_ONE_O, SERIAL_CTRL_PIN_ZERO_O};
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!RSTN_I);
   a_gp_drive: assert property (
      !STOP_I && !GP_CTRL_I[5] && GP_DIR_I[5] |=> !PORT_TRANSMIT_DATA_PIN_OE_N_O &&
      PORT_TRANSMIT_DATA_PIN_O == $past(GP_OUT_I[5])) else $error("gp drive wrong");
   a_gp_float: assert property (
      !STOP_I && !GP_CTRL_I[4] && !GP_DIR_I[4] |=> PORT_RECEIVE_DATA_PIN_OE_N_O)
      else $error("gp input driven");
   a_async_ctrl_in: assert property (
      !STOP_I && !SYNC_MODE_I && GP_CTRL_I[1:0] == 2'h3 |=> oe_n[1:0] == 2'h3)
      else $error("async control pin driven");
   a_sync_flags: assert property (
      !STOP_I && SYNC_MODE_I && GP_CTRL_I[1:0] == 2'h3 && XTX_EN_I == 2'h0
      |=> oe_n[1:0] == 2'h0 && ctl_o == $past(FLAG_I)) else $error("flag pins wrong");
   a_fs_dir: assert property (
      !STOP_I && GP_CTRL_I[2] |=> SERIAL_CTRL_PIN_TWO_OE_N_O == !$past(FS_OUT_I))
      else $error("frame sync direction wrong");
   a_bclk_dir: assert property (
      !STOP_I && GP_CTRL_I[3] |=> PORT_BIT_CLOCK_PIN_OE_N_O == !$past(CLK_OUT_I))
      else $error("bit clock direction wrong");
   a_rxd_input: assert property (
      GP_CTRL_I[4] |=> PORT_RECEIVE_DATA_PIN_OE_N_O) else $error("receive pin driven");
   a_tx_start: assert property (
      TX_TAKEN_O && GP_CTRL_I[5] && !STOP_I |=> !PORT_TRANSMIT_DATA_PIN_OE_N_O)
      else $error("transmit pin not driven");
   a_taken_gap: assert property (
      TX_TAKEN_O |=> !TX_TAKEN_O [*8]) else $error("word taken too soon");
   a_stop_off: assert property (
      STOP_I |=> oe_n == 6'h3F) else $error("pin driven in stop");
   a_stop_keep: assert property (
      !STOP_I ##1 STOP_I |=> KEEP_EN_O == ~$past(oe_n)) else $error("keeper wrong");
   a_stop_hold: assert property (
      STOP_I |=> $stable(GP_LEVEL_O) && $stable(PORT_TRANSMIT_DATA_PIN_O))
      else $error("level moved in stop");
   c_rx_word: cover property (RX_VALID_O && RX_READY_I);
   c_tx_word: cover property (TX_TAKEN_O);
   c_overrun: cover property ($rose(RX_OVERRUN_O));
   c_stop: cover property (STOP_I ##1 STOP_I);
endmodule // sspsl_sva

bind sspsl_top sspsl_sva chk_u (.*);

// ### test/sspsl_codec.sv
// Far-side codec model: bit clock, frame sync and receive data
module sspsl_codec (
   output logic clk_o,
   output logic fs_o,
   output logic dat_o
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      clk_o = 1'b0;
      fs_o = 1'b0;
      dat_o = 1'b0;
   end
   // Data set after the fall, sampled by the port at the rise
   task automatic bit_out(input logic f, input logic d);
      fs_o = f;
      dat_o = d;
      #40 clk_o = 1'b1;
      #40 clk_o = 1'b0;
   endtask
   // Two idle clocks let the enable cross before the sync bit
   task automatic send(input logic [15:0] w);
      bit_out(1'b0, w[0]);
      bit_out(1'b0, ~w[0]);
      bit_out(1'b1, ~w[15]);
      for (int b = 15; b >= 0; b--) begin
         bit_out(1'b0, w[b]);
      end
      fs_o = 1'b0;
      // Released line shows the inverse, never a stale bit
      dat_o = ~w[0];
   endtask
endmodule // sspsl_codec

// ### test/sspsl_tb_top.sv
// Self-checking testbench for the serial port pin layer
module sspsl_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic REF_CLK_I = 1'b0;
   logic RSTN_I = 1'b0;
   logic [5:0] GP_CTRL_I = 6'h00, GP_DIR_I = 6'h00, GP_OUT_I = 6'h00;
   logic [5:0] GP_LEVEL_O, KEEP_EN_O, o, oe_n, pad, ext, ext_q = 6'h00;
   logic SYNC_MODE_I = 1'b0, CLK_OUT_I = 1'b0, FS_OUT_I = 1'b0, STOP_I = 1'b0;
   logic RX_READY_I = 1'b0, RX_OVR_CLR_I = 1'b0, TX_TAKEN_O, RX_VALID_O, RX_OVERRUN_O;
   logic [1:0] FLAG_I = 2'h0, XTX_EN_I = 2'h0;
   logic [15:0] TX_WORD_I = 16'h0000, RX_DATA_O;
   logic p_clk, p_fs, p_dat;
   int bad_count = 0;
   int tests_run = 0;
   logic [15:0] rx_q[$], tx_q[$];
   always #12.5 REF_CLK_I = ~REF_CLK_I;
   assign ext = {ext_q[5], p_dat, p_clk, p_fs, ext_q[1:0]};
   // Resolved pads fed back to every input
   assign pad = (o & ~oe_n) | (ext & oe_n);
   sspsl_codec p_u (.clk_o(p_clk), .fs_o(p_fs), .dat_o(p_dat));
   sspsl_top dut_u (
      .SERIAL_CTRL_PIN_ZERO_I(pad[0]), .SERIAL_CTRL_PIN_ZERO_O(o[0]),
      .SERIAL_CTRL_PIN_ZERO_OE_N_O(oe_n[0]), .SERIAL_CTRL_PIN_ONE_I(pad[1]),
      .SERIAL_CTRL_PIN_ONE_O(o[1]), .SERIAL_CTRL_PIN_ONE_OE_N_O(oe_n[1]),
      .SERIAL_CTRL_PIN_TWO_I(pad[2]), .SERIAL_CTRL_PIN_TWO_O(o[2]),
      .SERIAL_CTRL_PIN_TWO_OE_N_O(oe_n[2]), .PORT_BIT_CLOCK_PIN_I(pad[3]),
      .PORT_BIT_CLOCK_PIN_O(o[3]), .PORT_BIT_CLOCK_PIN_OE_N_O(oe_n[3]),
      .PORT_RECEIVE_DATA_PIN_I(pad[4]), .PORT_RECEIVE_DATA_PIN_O(o[4]),
      .PORT_RECEIVE_DATA_PIN_OE_N_O(oe_n[4]), .PORT_TRANSMIT_DATA_PIN_I(pad[5]),
      .PORT_TRANSMIT_DATA_PIN_O(o[5]), .PORT_TRANSMIT_DATA_PIN_OE_N_O(oe_n[5]), .*);

   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic done(input string s);
      $display("test %s ended: %0d checks, %0d mismatches", s, tests_run, bad_count);
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Event 0: word taken; event 1: rise of the driven bit clock
   task automatic wait_ev(input int sel);
      logic prev;
      int n;
      prev = o[3];
      for (n = 0; n < 600; n++) begin
         @(negedge REF_CLK_I);
         if (sel == 0 ? TX_TAKEN_O === 1'b1 : (o[3] === 1'b1 && prev === 1'b0)) break;
         prev = o[3];
      end
      if (n == 600) begin
         check(16'h0000, 16'h0001, "event wait");
         stop_test();
      end
   endtask

   initial begin
      int i;
      logic [15:0] w, got, got0, got1, gotf;
      void'($urandom(32'h51BC_045C));
      repeat (8) @(posedge REF_CLK_I);
      check(oe_n, 6'h3F, "reset oe_n");
      repeat (8) @(posedge REF_CLK_I);
      RSTN_I <= 1'b1;
      check(oe_n, 6'h3F, "idle oe_n");
      for (i = 0; i < 4; i++) begin
         GP_DIR_I <= 6'($urandom);
         GP_OUT_I <= 6'($urandom);
         ext_q <= 6'($urandom);
         // Driven pins need pin reg, two sync flops and the level reg
         repeat (5) @(posedge REF_CLK_I);
         check(oe_n, 6'(~GP_DIR_I), "gp dir");
         check(o & GP_DIR_I, GP_OUT_I & GP_DIR_I, "gp out");
         check(GP_LEVEL_O, (GP_OUT_I & GP_DIR_I) | (ext & ~GP_DIR_I), "gp level");
      end
      done("gp");
      GP_DIR_I <= 6'h2B;
      repeat (4) @(posedge REF_CLK_I);
      STOP_I <= 1'b1;
      w = {10'h000, (GP_OUT_I & 6'h2B) | (ext & 6'h14)};
      repeat (2) @(posedge REF_CLK_I);
      check(oe_n, 6'h3F, "stop oe_n");
      check(KEEP_EN_O, 6'h2B, "keep");
      check(o & 6'h2B, GP_OUT_I & 6'h2B, "stop out");
      ext_q <= ~ext_q;
      repeat (4) @(posedge REF_CLK_I);
      check(GP_LEVEL_O, w[5:0], "stop level");
      STOP_I <= 1'b0;
      GP_DIR_I <= 6'h00;
      done("stop");
      for (i = 0; i < 8; i++) begin
         SYNC_MODE_I <= i[2];
         FLAG_I <= i[1:0];
         GP_CTRL_I <= 6'h03;
         repeat (3) @(posedge REF_CLK_I);
         check(oe_n[1:0], i[2] ? 2'b00 : 2'b11, "ctrl oe_n");
         if (i[2]) check(o[1:0], i[1:0], "flag");
      end
      done("modes");
      GP_CTRL_I <= 6'h1C;
      SYNC_MODE_I <= 1'b1;
      // Ten words into a store of nine: the last must be dropped
      for (i = 0; i < 10; i++) begin
         w = 16'($urandom);
         if (rx_q.size() < 9) rx_q.push_back(w);
         p_u.send(w);
      end
      repeat (20) @(posedge REF_CLK_I);
      check(RX_OVERRUN_O, 1'b1, "overrun");
      RX_READY_I <= 1'b1;
      for (i = 0; i < 300 && rx_q.size() > 0; i++) begin
         @(negedge REF_CLK_I);
         if (RX_VALID_O === 1'b1) check(RX_DATA_O, rx_q.pop_front(), "rx word");
      end
      check(16'(rx_q.size()), 16'h0000, "rx left");
      repeat (4) @(posedge REF_CLK_I);
      check(RX_VALID_O, 1'b0, "rx empty");
      RX_OVR_CLR_I <= 1'b1;
      @(posedge REF_CLK_I);
      RX_OVR_CLR_I <= 1'b0;
      repeat (2) @(posedge REF_CLK_I);
      check(RX_OVERRUN_O, 1'b0, "overrun clear");
      done("receive");
      w = 16'($urandom);
      tx_q.push_back(w);
      TX_WORD_I <= w;
      XTX_EN_I <= 2'h3;
      GP_CTRL_I <= 6'h2F;
      CLK_OUT_I <= 1'b1;
      FS_OUT_I <= 1'b1;
      for (i = 0; i < 2; i++) begin
         wait_ev(0);
         @(posedge REF_CLK_I);
         w = 16'($urandom);
         TX_WORD_I <= w;
         tx_q.push_back(w);
         for (int b = 15; b >= 0; b--) begin
            wait_ev(1);
            got[b] = oe_n[5] ? 1'bx : pad[5];
            got0[b] = oe_n[0] ? 1'bx : pad[0];
            got1[b] = oe_n[1] ? 1'bx : pad[1];
            gotf[b] = oe_n[2] ? 1'bx : pad[2];
         end
         w = tx_q.pop_front();
         check(got, w, "tx word");
         check(got0, w, "extra tx word");
         check(got1, w, "second extra tx word");
         // Frame sync only in the bit period before the next MSB
         check(gotf, 16'h0001, "frame sync out");
      end
      done("transmit");
      stop_test();
   end
endmodule // sspsl_tb_top
